// [core/dram_port_pkg.sv]
// constants, states and carrier structs for the module dram port
// assumes one 100 MHz core clock and a board-side dram already initialised
package dram_port_pkg;

    // ==========================================================
    // geometry
    localparam int RANKS = 6;         // row strobe / chip select count
    localparam int LANES = 8;         // byte lanes on the data bus
    localparam int ADDR_W = 14;       // multiplexed address pins
    localparam int COL_W = 10;        // column bits
    localparam int RANK_W = 3;        // rank select bits
    localparam int BURST = 4;         // qwords per read burst

    // ==========================================================
    // pin polarity and fixed codes
    localparam logic [13:0] ADDR_INV = 14'h1BFF;    // low-true address pins
    localparam logic [13:0] ADDR_ALLBANK = 14'h0400; // a10 high: all banks
    localparam logic [13:0] ADDR_IDLE = 14'h0000;   // parked address

    // ==========================================================
    // access schedule, in counter steps from the accept cycle
    localparam logic [4:0] CNT_ACT = 5'h01;   // row open
    localparam logic [4:0] CNT_CMD = 5'h03;   // column command
    localparam logic [4:0] SD_FIRST = 5'h08;  // first sdram read beat
    localparam logic [4:0] SD_LAST = 5'h0B;   // last sdram read beat
    localparam logic [4:0] EDO_FIRST = 5'h07; // first edo read beat
    localparam logic [4:0] EDO_LAST = 5'h0D;  // last edo read beat
    localparam logic [4:0] EDO_CAS_LAST = 5'h09; // last edo column strobe
    localparam logic [4:0] CNT_PRE = 5'h0E;   // row close / precharge
    localparam logic [4:0] CNT_END = 5'h0F;   // back to idle

    // ==========================================================
    // controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,  // waiting for a request
        ST_BUSY = 2'b01,  // running one access
        ST_SELF = 2'b10   // memory kept in self refresh
    } state_e;

    // ==========================================================
    // user request
    typedef struct packed {
        logic valid;               // request present
        logic write;               // 1 write one qword, 0 read a burst
        logic [2:0] rank;          // which strobe / select
        logic [13:0] row;          // row address
        logic [9:0] col;           // start column
        logic [63:0] wdata;        // write data
        logic [7:0] byte_en;       // write byte enables
    } mem_req_s;

    // registered pin levels
    typedef struct packed {
        logic [5:0] rs_cs_n;       // row strobe or chip select
        logic [7:0] cas_dqm;       // column strobe or byte mask
        logic [13:0] addr;         // address pin levels
        logic we_n;                // write enable
        logic sd_ras_n;            // sdram row strobe
        logic sd_cas_n;            // sdram column strobe
        logic cke;                 // clock enable
        logic [63:0] dq_out;       // data out
        logic dq_oe;               // data driven
    } mem_pins_s;

endpackage : dram_port_pkg

// [core/dram_port.sv]
// edo / sdram port controller: one access at a time, pins all registered
// assumes the dram is initialised by other logic (sdram burst length 4,
// cas latency 2) and that mode, suspend and power-down come from core logic
//
// Function
// R1: ecc lines never driven, never checked
// R2: edo mode: six row strobes select row
// R3: sdram mode: same pins are chip selects
// R4: edo mode: eight column strobes select column
// R5: sdram mode: column pins become byte masks
// R6: row and column multiplexed on address bus
// R7: only second address copy used
// R8: first write enable drives data writes
// R9: sdram row strobe latches row, precharges
// R10: sdram column strobe latches column access
// R11: clock enable low means power-down
// R12: spare clock enable unused
// R13: 64-bit data bus driven writes, sampled reads
// R14: reads burst 7-2-2-2 edo, 8-1-1-1 sdram
// R15: suspend puts memory into self refresh
// R16: one memory type, chosen before access
`timescale 1ns/1ps
module dram_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sdram_mode,
    input wire logic suspend,
    input wire logic power_down,
    input wire dram_port_pkg::mem_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [63:0] rsp_rdata,
    output logic [5:0] row_strobe_or_chip_select_n,
    output logic [7:0] column_strobe_or_byte_mask,
    output logic [13:0] memory_address_bus,
    output logic [13:0] unused_address_copy,
    output logic [1:0] write_enable_n,
    output logic [1:0] sdram_row_strobe_n,
    output logic [1:0] sdram_column_strobe_n,
    output logic clock_enable_primary,
    output logic clock_enable_spare,
    input wire logic [63:0] memory_data_bus_in,
    output logic [63:0] memory_data_bus_out,
    output logic memory_data_bus_oe,
    input wire logic [7:0] ecc_check_lines_in,
    output logic [7:0] ecc_check_lines_out,
    output logic ecc_check_lines_oe
);
    import dram_port_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        state_e state;          // controller state
        logic [4:0] cnt;        // schedule counter
        logic sdram;            // latched memory type
        logic ready;            // request may be taken
        mem_req_s req;          // request in progress
        mem_pins_s pins;        // pin levels
        logic rsp_valid;        // read beat valid
        logic [63:0] rsp_data;  // read beat data
        logic [63:0] sync1;     // data pins, first stage
        logic [63:0] sync2;     // data pins, second stage
        logic [7:0] ecc_out;    // ecc pins, parked
        logic ecc_oe;           // ecc pins, never driven
    } state_s;

    state_s st_r;               // registered state
    state_s st_nxt;             // next state
    logic [5:0] rank_sel_n;     // one low bit for the addressed rank
    logic [13:0] addr_log;      // logical address before pin polarity
    logic [1:0] beat;           // edo burst beat
    logic [4:0] since_cmd;      // steps since the column command
    logic rd_beat;              // this step returns a read beat
    logic accept;               // request taken this cycle

    assign accept = req.valid && st_r.ready && st_r.state == ST_IDLE;
    assign rank_sel_n = ~(6'h01 << st_r.req.rank);
    assign since_cmd = 5'(st_r.cnt - CNT_CMD);
    assign beat = since_cmd[2:1];

    // read beats: every step for sdram, every second step for edo
    always_comb begin
        if (st_r.sdram) begin
            rd_beat = st_r.cnt >= SD_FIRST && st_r.cnt <= SD_LAST; // [R14]
        end else begin
            rd_beat = st_r.cnt >= EDO_FIRST && st_r.cnt <= EDO_LAST
                && st_r.cnt[0]; // [R14]
        end
    end

    // ==========================================================
    // next state and pin levels
    always_comb begin
        st_nxt = st_r;
        addr_log = ADDR_IDLE;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.sync1 = memory_data_bus_in;        // [R13]
        st_nxt.sync2 = st_r.sync1;
        st_nxt.ecc_out = 8'h00;                   // [R1]
        st_nxt.ecc_oe = 1'b0;                     // [R1]
        // parked pins: all strobes high, masks set, bus released
        st_nxt.pins.rs_cs_n = 6'h3F;
        st_nxt.pins.cas_dqm = 8'hFF;
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.sd_ras_n = 1'b1;
        st_nxt.pins.sd_cas_n = 1'b1;
        st_nxt.pins.cke = !power_down;            // [R11]
        st_nxt.pins.dq_out = st_r.req.wdata;
        st_nxt.pins.dq_oe = 1'b0;
        case (st_r.state)
            ST_IDLE: begin
                // type only follows its input between accesses
                st_nxt.sdram = sdram_mode;        // [R16]
                if (accept) begin
                    st_nxt.state = ST_BUSY;
                    st_nxt.cnt = CNT_ACT;
                    st_nxt.req = req;
                end else if (suspend) begin
                    st_nxt.state = ST_SELF;
                    st_nxt.cnt = 5'h00;
                end
            end
            ST_BUSY: begin
                st_nxt.cnt = 5'(st_r.cnt + 5'h01);
                if (st_r.sdram) begin
                    if (st_r.cnt == CNT_ACT) begin
                        // activate: select, row strobe, row on the bus
                        st_nxt.pins.rs_cs_n = rank_sel_n;     // [R3]
                        st_nxt.pins.sd_ras_n = 1'b0;          // [R9]
                        addr_log = st_r.req.row;              // [R6]
                    end else if (st_r.cnt == CNT_CMD) begin
                        // read or write: column strobe, column on the bus
                        st_nxt.pins.rs_cs_n = rank_sel_n;     // [R3]
                        st_nxt.pins.sd_cas_n = 1'b0;          // [R10]
                        addr_log = {4'h0, st_r.req.col};      // [R6]
                        st_nxt.pins.we_n = !st_r.req.write;   // [R8]
                        st_nxt.pins.dq_oe = st_r.req.write;   // [R13]
                        st_nxt.pins.cas_dqm = st_r.req.write
                            ? ~st_r.req.byte_en : 8'h00;      // [R5]
                    end else if (st_r.cnt == CNT_PRE) begin
                        // precharge all banks of the rank
                        st_nxt.pins.rs_cs_n = rank_sel_n;     // [R3]
                        st_nxt.pins.sd_ras_n = 1'b0;          // [R9]
                        st_nxt.pins.we_n = 1'b0;
                        addr_log = ADDR_ALLBANK;
                    end else if (!st_r.req.write && st_r.cnt > CNT_CMD) begin
                        st_nxt.pins.cas_dqm = 8'h00;          // [R5]
                    end
                end else begin
                    // edo: row strobe held from the row step up to the precharge step
                    if (st_r.cnt < CNT_PRE) begin
                        st_nxt.pins.rs_cs_n = rank_sel_n;     // [R2]
                        addr_log = (st_r.cnt < CNT_CMD) ? st_r.req.row
                            : {4'h0, 10'(st_r.req.col + {8'h00, beat})}; // [R6]
                    end
                    if (st_r.req.write) begin
                        // data and write enable lead the column strobe
                        if (st_r.cnt == CNT_CMD) begin
                            st_nxt.pins.cas_dqm = ~st_r.req.byte_en; // [R4]
                        end
                        if (st_r.cnt >= CNT_CMD - 5'h01 && st_r.cnt <= CNT_CMD) begin
                            st_nxt.pins.we_n = 1'b0;          // [R8]
                            st_nxt.pins.dq_oe = 1'b1;         // [R13]
                        end
                    end else if (st_r.cnt >= CNT_CMD && st_r.cnt <= EDO_CAS_LAST
                        && st_r.cnt[0]) begin
                        st_nxt.pins.cas_dqm = 8'h00;          // [R4]
                    end
                end
                if (!st_r.req.write && rd_beat) begin
                    st_nxt.rsp_valid = 1'b1;                  // [R14]
                    st_nxt.rsp_data = st_r.sync2;             // [R13]
                end
                if (st_r.cnt == CNT_END) begin
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_SELF: begin
                // first step enters self refresh, later steps hold it
                st_nxt.cnt = 5'h01;
                if (st_r.sdram) begin
                    st_nxt.pins.cke = 1'b0;                   // [R15]
                    if (st_r.cnt == 5'h00 && suspend) begin
                        st_nxt.pins.rs_cs_n = 6'h00;
                        st_nxt.pins.sd_ras_n = 1'b0;
                        st_nxt.pins.sd_cas_n = 1'b0;
                    end
                end else if (suspend) begin
                    // cas before ras, held: the edo parts refresh alone
                    // strobes park on the exit step so idle never shows them low
                    st_nxt.pins.cas_dqm = 8'h00;              // [R15]
                    if (st_r.cnt != 5'h00) begin
                        st_nxt.pins.rs_cs_n = 6'h00;
                    end
                end
                if (!suspend) begin
                    st_nxt.state = ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
        st_nxt.pins.addr = addr_log ^ ADDR_INV;
        st_nxt.ready = st_nxt.state == ST_IDLE;
    end

    // ==========================================================
    // state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.pins.rs_cs_n <= 6'h3F;
            st_r.pins.cas_dqm <= 8'hFF;
            st_r.pins.addr <= ADDR_INV;
            st_r.pins.we_n <= 1'b1;
            st_r.pins.sd_ras_n <= 1'b1;
            st_r.pins.sd_cas_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs, all from the state register
    assign req_ready = st_r.ready;
    assign rsp_valid = st_r.rsp_valid;
    assign rsp_rdata = st_r.rsp_data;
    assign row_strobe_or_chip_select_n = st_r.pins.rs_cs_n;
    assign column_strobe_or_byte_mask = st_r.pins.cas_dqm;
    assign memory_address_bus = st_r.pins.addr;
    assign unused_address_copy = st_r.ecc_out[0] ? ADDR_INV : ADDR_IDLE; // [R7]
    assign write_enable_n = {st_r.pins.we_n, st_r.pins.we_n};     // [R8]
    assign sdram_row_strobe_n = {2{st_r.pins.sd_ras_n}};
    assign sdram_column_strobe_n = {2{st_r.pins.sd_cas_n}};
    assign clock_enable_primary = st_r.pins.cke;
    assign clock_enable_spare = st_r.ecc_oe;                      // [R12]
    assign memory_data_bus_out = st_r.pins.dq_out;
    assign memory_data_bus_oe = st_r.pins.dq_oe;
    assign ecc_check_lines_out = st_r.ecc_out;
    assign ecc_check_lines_oe = st_r.ecc_oe;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ecc_never_driven: assert property (!ecc_check_lines_oe) // [R1]
        else $error("ecc lines driven");
    a_edo_row_held: assert property (st_r.state == ST_BUSY && !st_r.sdram
        && st_r.cnt == CNT_CMD |=> row_strobe_or_chip_select_n == rank_sel_n) // [R2]
        else $error("edo row strobe not held");
    a_sd_one_select: assert property (st_r.state != ST_SELF
        |-> $onehot0(~row_strobe_or_chip_select_n)) // [R3]
        else $error("more than one select low");
    a_sd_write_mask: assert property (accept && sdram_mode && req.write
        |=> ##3 column_strobe_or_byte_mask == ~$past(req.byte_en, 4)) // [R5]
        else $error("byte mask wrong");
    a_addr_copy_idle: assert property (unused_address_copy == ADDR_IDLE) // [R7]
        else $error("unused address copy moved");
    a_we_with_data: assert property (memory_data_bus_oe |-> !write_enable_n[0]) // [R8]
        else $error("data driven without write enable");
    a_spare_cke_low: assert property (!clock_enable_spare) // [R12]
        else $error("spare clock enable raised");
    a_sd_burst_timing: assert property (accept && sdram_mode && !req.write
        |-> ##9 rsp_valid [*4] ##1 !rsp_valid) // [R14]
        else $error("sdram burst not 8-1-1-1");
    a_edo_burst_timing: assert property (accept && !sdram_mode && !req.write
        |-> ##7 !rsp_valid ##1 rsp_valid ##1 !rsp_valid ##1 rsp_valid
        ##1 !rsp_valid ##1 rsp_valid ##1 !rsp_valid ##1 rsp_valid) // [R14]
        else $error("edo burst not 7-2-2-2");
    a_self_cke_low: assert property (st_r.state == ST_SELF && st_r.sdram
        |=> !clock_enable_primary) // [R15]
        else $error("self refresh without clock enable low");
    a_mode_fixed: assert property (st_r.state == ST_BUSY |=> $stable(st_r.sdram)) // [R16]
        else $error("memory type changed mid access");

    c_sd_read: cover property (accept && sdram_mode && !req.write ##9 rsp_valid);
    c_edo_read: cover property (accept && !sdram_mode && !req.write ##8 rsp_valid);
    c_write: cover property (accept && req.write ##4 memory_data_bus_oe);
    c_self: cover property (st_r.state == ST_SELF ##1 st_r.state == ST_IDLE);

endmodule : dram_port

// [sim/dram_model.sv]
// behavioural board memory: edo or sdram ranks behind the dram port pins
// assumes pins are registered by the port and change on the core_clk rising edge
`timescale 1ns/1ps
module dram_model (
    input wire logic core_clk,
    input wire logic sdram_mode,
    input wire logic [5:0] sel_n,
    input wire logic [7:0] strobe_mask,
    input wire logic [13:0] addr,
    input wire logic we_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic cke,
    input wire logic [63:0] dq_out,
    input wire logic dq_oe,
    output logic [63:0] dq_in
);
    import dram_port_pkg::*;
    // ==========================================================
    // storage and read pipeline
    logic [63:0] mem [logic [9:0]]; // one qword per column, rank not kept
    logic [9:0] c = 10'h000;        // logical column on the pins
    logic [9:0] rcol = 10'h000;     // next burst column
    int lat = 0;                    // cycles before the first sdram beat
    int left = 0;                   // sdram beats still to send
    logic edo_rd = 1'b0;            // edo data held after strobe rises
    logic hold;                     // bus driven this cycle
    initial dq_in = 64'h0;
    // unwritten cells read back a column-derived pattern
    function automatic logic [63:0] dflt(input logic [9:0] a);
        return {32'h5A5A_0000, 22'h0, a};
    endfunction : dflt
    // a byte is stored where its mask or strobe is low
    task automatic wr(input logic [9:0] a);
        logic [63:0] m;
        m = mem.exists(a) ? mem[a] : dflt(a);
        for (int i = 0; i < 8; i++) begin
            if (!strobe_mask[i] && dq_oe) m[i*8 +: 8] = dq_out[i*8 +: 8];
        end
        mem[a] = m;
    endtask : wr
    // ==========================================================
    // look at the pins just after each edge, answer like a real part
    always @(posedge core_clk) begin
        #1;
        c = 10'(addr ^ ADDR_INV);
        hold = 1'b0;
        if (lat > 0) lat--;
        // cas latency two, burst of four wrapping in its block
        if (sdram_mode && lat == 0 && left > 0) begin
            dq_in = mem.exists(rcol) ? mem[rcol] : dflt(rcol);
            rcol = {rcol[9:2], rcol[1:0] + 2'h1};
            left--;
            hold = 1'b1;
        end
        // commands count only with a select low and clock enabled
        if (sdram_mode && cke && sel_n != 6'h3F && ras_n && !cas_n) begin
            if (!we_n) begin
                wr(c);
            end else begin
                rcol = c;
                left = 4;
                // the part takes the command one edge after we see it
                lat = 2;
            end
        end
        // edo: row strobe then column strobes pick the cell
        if (!sdram_mode && sel_n != 6'h3F && strobe_mask != 8'hFF) begin
            if (!we_n) begin
                wr(c);
            end else begin
                dq_in = mem.exists(c) ? mem[c] : dflt(c);
                edo_rd = 1'b1;
                hold = 1'b1;
            end
        end else if (!sdram_mode && sel_n != 6'h3F && edo_rd) begin
            hold = 1'b1; // extended data out keeps the last cell
        end
        if (sel_n == 6'h3F) edo_rd = 1'b0;
        // a released bus must never look like the last value
        if (!hold) dq_in = ~dq_in;
    end
endmodule : dram_model

// [sim/dram_port_tb_top.sv]
// self-checking bench for the dram port with a board memory model
// assumes the port's pins are registered and its request handshake is level based
`timescale 1ns/1ps
module dram_port_tb_top;
    import dram_port_pkg::*;
    // ==========================================================
    // stimulus and observed pins
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sdram_mode = 1'b1;
    logic suspend = 1'b0;
    logic power_down = 1'b0;
    mem_req_s req = '0;
    logic [7:0] ecc_in = 8'h5A; // ignored by the port, tied
    logic req_ready, rsp_valid, cke, cke_spare, dq_oe, ecc_oe;
    logic [63:0] rsp_rdata, dq_in, dq_out;
    logic [5:0] sel_n;
    logic [7:0] cas_dqm, ecc_out;
    logic [13:0] addr, addr_copy;
    logic [1:0] we_n, row_cmd_n, col_cmd_n;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int beat_cyc [$];
    logic [63:0] beat_dat [$];
    logic [5:0] sel_seen;
    logic [7:0] mask_seen;
    logic [1:0] we_seen, ras_seen, cas_seen;
    logic [13:0] row_seen;
    initial forever #5 core_clk = ~core_clk;
    dram_port u_dut (.core_clk(core_clk), .rst(rst), .sdram_mode(sdram_mode),
        .suspend(suspend), .power_down(power_down), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .row_strobe_or_chip_select_n(sel_n),
        .column_strobe_or_byte_mask(cas_dqm), .memory_address_bus(addr),
        .unused_address_copy(addr_copy), .write_enable_n(we_n), .sdram_row_strobe_n(row_cmd_n),
        .sdram_column_strobe_n(col_cmd_n), .clock_enable_primary(cke),
        .clock_enable_spare(cke_spare), .memory_data_bus_in(dq_in),
        .memory_data_bus_out(dq_out), .memory_data_bus_oe(dq_oe),
        .ecc_check_lines_in(ecc_in), .ecc_check_lines_out(ecc_out),
        .ecc_check_lines_oe(ecc_oe));
    dram_model u_mem (.core_clk(core_clk), .sdram_mode(sdram_mode), .sel_n(sel_n),
        .strobe_mask(cas_dqm), .addr(addr), .we_n(we_n[0]), .ras_n(row_cmd_n[0]),
        .cas_n(col_cmd_n[0]), .cke(cke), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    // ==========================================================
    // pin monitor: beats with their edge index, strobes seen low
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (rsp_valid === 1'b1) begin
            beat_cyc.push_back(cyc);
            beat_dat.push_back(rsp_rdata);
        end
        sel_seen <= sel_seen & sel_n;
        mask_seen <= mask_seen & cas_dqm;
        we_seen <= we_seen & we_n;
        ras_seen <= ras_seen & row_cmd_n;
        cas_seen <= cas_seen & col_cmd_n;
        if (row_cmd_n === 2'b00 && we_n === 2'b11) row_seen <= addr ^ ADDR_INV;
    end
    // ==========================================================
    // shared helpers
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    function automatic logic [63:0] dflt(input logic [9:0] a);
        return {32'h5A5A_0000, 22'h0, a};
    endfunction : dflt
    // one request held until the edge that takes it, then 20 cycles to finish
    task automatic access(input logic w, input logic [2:0] rk, input logic [13:0] rw,
        input logic [9:0] cl, input logic [63:0] wd, input logic [7:0] be, output int t0);
        int n;
        @(negedge core_clk);
        sel_seen = 6'h3F;
        mask_seen = 8'hFF;
        {we_seen, ras_seen, cas_seen} = 6'h3F;
        beat_cyc.delete();
        beat_dat.delete();
        @(posedge core_clk);
        req <= '{valid: 1'b1, write: w, rank: rk, row: rw, col: cl, wdata: wd, byte_en: be};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        t0 = cyc;
        req.valid <= 1'b0;
        if (n >= 40) begin
            err_total++;
            finish_test();
        end
        repeat (20) @(posedge core_clk);
    endtask : access
    // four beats, first data given, spacing from the taken edge
    task automatic chk_burst(input logic [9:0] cl, input logic [63:0] b0, input int t0,
        input int first, input int step);
        chk(64'(beat_dat.size()), 64'h4);
        for (int i = 0; i < 4 && i < beat_dat.size(); i++) begin
            chk(beat_dat[i], (i == 0) ? b0 : dflt(cl + 10'(i)));
            chk(64'(beat_cyc[i] - t0), 64'(first + step * i));
        end
    endtask : chk_burst
    // ==========================================================
    // scenarios
    task automatic s_reset();
        chk(64'(addr_copy), 64'h0);
        chk(64'(cke_spare), 64'h0);
        chk(64'({ecc_out, ecc_oe}), 64'h0);
        chk(64'({sel_n, cas_dqm, req_ready}), 64'h7FFF);
    endtask : s_reset
    task automatic s_sdram();
        int t0;
        access(1'b1, 3'h2, 14'h1234, 10'h010, 64'h1122_3344_5566_7788, 8'h0F, t0);
        chk(64'(we_seen), 64'h0);
        access(1'b0, 3'h2, 14'h1234, 10'h010, 64'h0, 8'h00, t0);
        chk_burst(10'h010, {32'h5A5A_0000, 32'h5566_7788}, t0, 9, 1);
        chk(64'(sel_seen), 64'h3B);
        chk(64'({ras_seen, cas_seen}), 64'h0);
        chk(64'(row_seen), 64'h1234);
    endtask : s_sdram
    task automatic s_edo();
        int t0;
        @(posedge core_clk);
        sdram_mode <= 1'b0;
        access(1'b1, 3'h4, 14'h0ABC, 10'h020, 64'hCAFE_F00D_0000_0000, 8'hF0, t0);
        access(1'b0, 3'h4, 14'h0ABC, 10'h020, 64'h0, 8'h00, t0);
        chk_burst(10'h020, {32'hCAFE_F00D, 32'h0000_0020}, t0, 8, 2);
        chk(64'(sel_seen), 64'h2F);
        chk(64'(mask_seen), 64'h0);
    endtask : s_edo
    task automatic s_power();
        @(posedge core_clk);
        power_down <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(64'(cke), 64'h0);
        power_down <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(64'(cke), 64'h1);
    endtask : s_power
    task automatic s_suspend();
        for (int m = 1; m >= 0; m--) begin
            @(posedge core_clk);
            sdram_mode <= m[0];
            suspend <= 1'b1;
            repeat (4) @(posedge core_clk);
            // sdram: the entry command lasts one cycle, then the selects park
            if (m == 1) chk(64'({cke, sel_n}), 64'h3F);
            else chk(64'({sel_n, cas_dqm}), 64'h0);
            suspend <= 1'b0;
            repeat (4) @(posedge core_clk);
            chk(64'(req_ready), 64'h1);
        end
    endtask : s_suspend
    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        s_reset();
        s_sdram();
        s_edo();
        s_power();
        s_suspend();
        finish_test();
    end
endmodule : dram_port_tb_top
